//--- rtl/abe_core.v
// Function
// - Add register to register, optional carry; one clock; Z,C,N,V,H updated.
// - Word add immediate on register pair; Z,C,N,V,S updated; two clocks.
// - Subtract register or constant, write back; Z,C,N,V,H; one clock.
// - Subtract with borrow also subtracts carry; Z,C,N,V,H; one clock.
// - Word subtract immediate on register pair; Z,C,N,V,S; two clocks.
// - AND, OR, XOR with register; AND, OR with constant; Z,N,V,S only; one clock.
// - Bit set ORs constant; bit clear ANDs with inverted constant.
// - Test ANDs register with itself, value kept, Z,N,V updated.
// - Pointer jump loads PC from Z pair, flags kept, two clocks.
// - Pointer call loads PC from Z pair, flags kept, three clocks.
// - Compare-skip-equal skips next instruction when equal, flags kept.
// - Compare immediate sets Z,N,V,C,H from difference, writes nothing.
// - Skip on register bit clear or set, flags kept, one to three clocks.
// - Skip on I/O bit clear or set, flags kept.
// - Flag branch adds offset plus one when flag matches; 1 or 2 clocks.
//
// Register access over AHB-Lite and the address map were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
`include "abe_consts.vh"

module abe_core (
    input  wire         REF_CLK,
    input  wire         RESET,
    input  wire         HSEL,
    input  wire [31:0]  HADDR,
    input  wire [1:0]   HTRANS,
    input  wire         HWRITE,
    input  wire [2:0]   HSIZE,
    input  wire [31:0]  HWDATA,
    input  wire         HREADY,
    output reg  [31:0]  HRDATA,
    output reg          HREADYOUT,
    output reg          HRESP,
    output reg  [15:0]  PM_ADDR,
    input  wire [15:0]  PM_DATA,
    input  wire [255:0] IO_BITS,
    output reg  [7:0]   FLAGS_OUT
);
    // ========================================================
    // States
    localparam ST_EXEC  = 3'd0;
    localparam ST_WORD2 = 3'd1;
    localparam ST_SKIP  = 3'd2;
    localparam ST_STALL = 3'd3;
    localparam ST_IDLE  = 3'd4;

    reg  [2:0]  state_r;
    reg  [2:0]  state_nxt;
    reg  [15:0] pc_r;
    reg  [15:0] pc_nxt;
    reg  [7:0]  flags_r;
    reg  [7:0]  flags_nxt;
    reg  [1:0]  stall_r;
    reg  [1:0]  stall_nxt;
    reg  [7:0]  hi_r;
    reg  [7:0]  hi_nxt;
    reg  [4:0]  hi_addr_r;
    reg  [4:0]  hi_addr_nxt;
    reg  [3:0]  sp_r;
    reg  [3:0]  sp_nxt;
    reg         run_r;
    reg         push_en;
    reg  [15:0] push_val;
    reg  [15:0] ret_stack [0:15];

    // ========================================================
    // Register file and ALU
    wire [15:0] instr = PM_DATA;
    wire [4:0]  d_full = instr[8:4];
    wire [4:0]  d_high = {1'b1, instr[7:4]};
    wire [4:0]  r_full = {instr[9], instr[3:0]};
    wire [7:0]  k_byte = {instr[11:8], instr[3:0]};
    wire [4:0]  w_lo   = {2'b11, instr[5:4], 1'b0};
    wire [15:0] k_word = {10'h000, instr[7:6], instr[3:0]};

    reg  [4:0]  ra;
    reg  [4:0]  rb;
    reg         we;
    reg  [4:0]  waddr;
    reg  [7:0]  wdata;
    reg  [2:0]  alu_op;
    reg  [7:0]  alu_b;
    reg         alu_cin;
    reg         alu_chain;
    wire [7:0]  rda;
    wire [7:0]  rdb;
    wire [15:0] z_word;
    wire [7:0]  alu_res;
    wire        alu_c;
    wire        alu_z;
    wire        alu_n;
    wire        alu_v;
    wire        alu_h;

    abe_regfile u_regs (
        .clk     (REF_CLK),
        .we      (we),
        .waddr   (waddr),
        .wdata   (wdata),
        .raddr_a (ra),
        .raddr_b (rb),
        .rdata_a (rda),
        .rdata_b (rdb),
        .z_word  (z_word)
    );

    abe_alu u_alu (
        .op    (alu_op),
        .a     (rda),
        .b     (alu_b),
        .cin   (alu_cin),
        .chain (alu_chain),
        .zin   (flags_r[`ABE_F_Z]),
        .res   (alu_res),
        .cf    (alu_c),
        .zf    (alu_z),
        .nf    (alu_n),
        .vf    (alu_v),
        .hf    (alu_h)
    );

    // ========================================================
    // Word arithmetic on a register pair
    wire [15:0] pair    = {rdb, rda};
    wire        is_subw = instr[8];
    wire [15:0] word_res = is_subw ? pair - k_word : pair + k_word;
    wire        w_v = is_subw ? (rdb[7] & ~word_res[15])
                              : (~rdb[7] & word_res[15]);
    wire        w_c = is_subw ? (word_res[15] & ~rdb[7])
                              : (~word_res[15] & rdb[7]);

    // ========================================================
    // Branch and skip helpers
    wire [15:0] br_target = pc_r + {{9{instr[9]}}, instr[9:3]} + 16'h0001;
    wire        flag_sel  = flags_r[instr[2:0]];
    wire        reg_bit   = rda[instr[2:0]];
    wire        io_bit    = IO_BITS[{instr[7:3], instr[2:0]}];
    wire [15:0] pc_inc    = pc_r + 16'h0001;
    wire        two_word  = (instr[15:10] == 6'b100100 &&
                             instr[3:0] == 4'h0) ||
                            (instr[15:9] == 7'b1001010 &&
                             instr[3:2] == 2'b11);

    // Apply arithmetic flags through an update mask
    task put_flags;
        input [7:0] mask;
        reg   [7:0] f;
        begin
            f = flags_r;
            f[`ABE_F_C] = alu_c;
            f[`ABE_F_Z] = alu_z;
            f[`ABE_F_N] = alu_n;
            f[`ABE_F_V] = alu_v;
            f[`ABE_F_H] = alu_h;
            f[`ABE_F_S] = alu_n ^ alu_v;
            flags_nxt = (f & mask) | (flags_r & ~mask);
        end
    endtask

    // ========================================================
    // Decode and execute
    always @* begin
        state_nxt   = state_r;
        pc_nxt      = pc_r;
        flags_nxt   = flags_r;
        stall_nxt   = stall_r;
        hi_nxt      = hi_r;
        hi_addr_nxt = hi_addr_r;
        sp_nxt      = sp_r;
        push_en     = 1'b0;
        push_val    = pc_inc;
        ra          = d_full;
        rb          = r_full;
        we          = 1'b0;
        waddr       = d_full;
        wdata       = alu_res;
        alu_op      = `ABE_ALU_ADD;
        alu_b       = rdb;
        alu_cin     = 1'b0;
        alu_chain   = 1'b0;
        case (state_r)
            ST_IDLE: begin
                if (run_r) begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_EXEC: begin
                pc_nxt = pc_inc;
                if (!run_r) begin
                    pc_nxt    = pc_r;
                    state_nxt = ST_IDLE;
                end else begin
                    casez (instr)
                        `ABE_OP_ADD, `ABE_OP_ADC: begin
                            alu_cin = instr[12] & flags_r[`ABE_F_C];
                            we = 1'b1;
                            put_flags(8'h3f);
                        end
                        `ABE_OP_SUB, `ABE_OP_SBCR, `ABE_OP_CP,
                        `ABE_OP_CPC: begin
                            alu_op    = `ABE_ALU_SUB;
                            alu_cin   = ~instr[12] & flags_r[`ABE_F_C];
                            alu_chain = ~instr[12];
                            we        = instr[11];
                            put_flags(8'h3f);
                        end
                        `ABE_OP_SUBK, `ABE_OP_SBCK, `ABE_OP_CPI: begin
                            ra        = d_high;
                            waddr     = d_high;
                            alu_op    = `ABE_ALU_SUB;
                            alu_b     = k_byte;
                            alu_cin   = ~instr[12] & flags_r[`ABE_F_C];
                            alu_chain = ~instr[12];
                            // Compare writes nothing back
                            we        = instr[14];
                            put_flags(8'h3f);
                        end
                        `ABE_OP_AND, `ABE_OP_EOR, `ABE_OP_OR: begin
                            // Test is AND of a register with itself
                            alu_op = instr[11] ? `ABE_ALU_OR :
                                     (instr[10] ? `ABE_ALU_EOR
                                                : `ABE_ALU_AND);
                            we = 1'b1;
                            put_flags(8'h1e);
                        end
                        `ABE_OP_ORK, `ABE_OP_ANDK: begin
                            ra     = d_high;
                            waddr  = d_high;
                            // Bit clear arrives here pre-inverted
                            alu_op = instr[12] ? `ABE_ALU_AND
                                               : `ABE_ALU_OR;
                            alu_b  = k_byte;
                            we     = 1'b1;
                            put_flags(8'h1e);
                        end
                        `ABE_OP_ADDW, `ABE_OP_SUBW: begin
                            ra    = w_lo;
                            rb    = w_lo + 5'h01;
                            waddr = w_lo;
                            wdata = word_res[7:0];
                            we    = 1'b1;
                            hi_nxt      = word_res[15:8];
                            hi_addr_nxt = w_lo + 5'h01;
                            flags_nxt[`ABE_F_Z] = word_res == 16'h0000;
                            flags_nxt[`ABE_F_N] = word_res[15];
                            flags_nxt[`ABE_F_V] = w_v;
                            flags_nxt[`ABE_F_C] = w_c;
                            flags_nxt[`ABE_F_S] = word_res[15] ^ w_v;
                            pc_nxt    = pc_r;
                            state_nxt = ST_WORD2;
                        end
                        `ABE_OP_PJMP: begin
                            pc_nxt    = z_word;
                            stall_nxt = 2'd1;
                            state_nxt = ST_STALL;
                        end
                        `ABE_OP_PCALL: begin
                            push_en   = 1'b1;
                            sp_nxt    = sp_r - 4'h1;
                            pc_nxt    = z_word;
                            stall_nxt = 2'd2;
                            state_nxt = ST_STALL;
                        end
                        `ABE_OP_COMPARE_SKIP_EQUAL: begin
                            if (rda == rdb) begin
                                state_nxt = ST_SKIP;
                            end
                        end
                        `ABE_OP_SKRC, `ABE_OP_SKRS: begin
                            ra = instr[8:4];
                            if (reg_bit == instr[9]) begin
                                state_nxt = ST_SKIP;
                            end
                        end
                        `ABE_OP_SKIOC, `ABE_OP_SKIOS: begin
                            if (io_bit == instr[9]) begin
                                state_nxt = ST_SKIP;
                            end
                        end
                        `ABE_OP_BRS, `ABE_OP_BRC: begin
                            if (flag_sel == ~instr[10]) begin
                                pc_nxt    = br_target;
                                stall_nxt = 2'd1;
                                state_nxt = ST_STALL;
                            end
                        end
                        default: begin
                            // Other instructions pass as one-clock no-ops
                            pc_nxt = pc_inc;
                        end
                    endcase
                end
            end
            ST_WORD2: begin
                waddr     = hi_addr_r;
                wdata     = hi_r;
                we        = 1'b1;
                pc_nxt    = pc_inc;
                state_nxt = ST_EXEC;
            end
            ST_SKIP: begin
                // The skipped word is on the fetch port now
                pc_nxt = pc_inc;
                if (two_word) begin
                    // Step over the second word of the skipped pair too
                    pc_nxt    = pc_r + 16'h0002;
                    stall_nxt = 2'd1;
                    state_nxt = ST_STALL;
                end else begin
                    state_nxt = ST_EXEC;
                end
            end
            ST_STALL: begin
                stall_nxt = stall_r - 2'd1;
                if (stall_r == 2'd1) begin
                    state_nxt = ST_EXEC;
                end
            end
            default: state_nxt = ST_IDLE;
        endcase
    end

    always @(posedge REF_CLK) begin
        if (push_en) begin
            ret_stack[sp_r] <= push_val;
        end
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            state_r   <= ST_IDLE;
            pc_r      <= `ABE_PC_RST;
            flags_r   <= `ABE_FLAGS_RST;
            stall_r   <= 2'd0;
            hi_r      <= 8'h00;
            hi_addr_r <= 5'h00;
            sp_r      <= `ABE_SP_RST;
            PM_ADDR   <= `ABE_PC_RST;
            FLAGS_OUT <= `ABE_FLAGS_RST;
        end else begin
            state_r   <= state_nxt;
            pc_r      <= pc_nxt;
            flags_r   <= flags_nxt;
            stall_r   <= stall_nxt;
            hi_r      <= hi_nxt;
            hi_addr_r <= hi_addr_nxt;
            sp_r      <= sp_nxt;
            PM_ADDR   <= pc_nxt;
            FLAGS_OUT <= flags_nxt;
        end
    end

    // ========================================================
    // AHB-Lite slave: zero wait states, always OKAY
    reg        wr_pend_r;
    reg  [7:0] wr_addr_r;
    wire       take = HSEL & HTRANS[1] & HREADY;
    reg [31:0] rd_val;

    always @* begin
        case (HADDR[7:0])
            `ABE_ADDR_CTRL:   rd_val = {31'h0000_0000, run_r};
            `ABE_ADDR_STATUS: rd_val = {20'h0_0000, sp_r, flags_r};
            `ABE_ADDR_PC:     rd_val = {16'h0000, pc_r};
            default:          rd_val = 32'h0000_0000;
        endcase
    end

    always @(posedge REF_CLK) begin
        if (RESET) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
            run_r     <= `ABE_CTRL_RST;
            HRDATA    <= 32'h0000_0000;
            HREADYOUT <= 1'b1;
            HRESP     <= 1'b0;
        end else begin
            wr_pend_r <= take & HWRITE;
            wr_addr_r <= HADDR[7:0];
            if (take & ~HWRITE) begin
                HRDATA <= rd_val;
            end
            if (wr_pend_r && wr_addr_r == `ABE_ADDR_CTRL) begin
                run_r <= HWDATA[`ABE_CTRL_RUN];
            end
        end
    end
endmodule // abe_core

`default_nettype wire

//--- rtl/abe_consts.vh
`ifndef ABE_CONSTS_VH
`define ABE_CONSTS_VH

// ============================================================
// Status flag bit positions
`define ABE_F_C 0
`define ABE_F_Z 1
`define ABE_F_N 2
`define ABE_F_V 3
`define ABE_F_S 4
`define ABE_F_H 5
`define ABE_F_T 6
`define ABE_F_I 7

// ============================================================
// Bus register byte offsets and fields
`define ABE_ADDR_CTRL   8'h00
`define ABE_ADDR_STATUS 8'h04
`define ABE_ADDR_PC     8'h08
`define ABE_CTRL_RUN    0
`define ABE_CTRL_RST    1'h0
`define ABE_FLAGS_RST   8'h00
`define ABE_PC_RST      16'h0000
`define ABE_SP_RST      4'hf

// ============================================================
// ALU operation codes
`define ABE_ALU_ADD 3'h0
`define ABE_ALU_SUB 3'h1
`define ABE_ALU_AND 3'h2
`define ABE_ALU_OR  3'h3
`define ABE_ALU_EOR 3'h4

// ============================================================
// Opcode patterns
`define ABE_OP_CPC    16'b0000_01??_????_????
`define ABE_OP_SBCR   16'b0000_10??_????_????
`define ABE_OP_ADD    16'b0000_11??_????_????
`define ABE_OP_COMPARE_SKIP_EQUAL   16'b0001_00??_????_????
`define ABE_OP_CP     16'b0001_01??_????_????
`define ABE_OP_SUB    16'b0001_10??_????_????
`define ABE_OP_ADC    16'b0001_11??_????_????
`define ABE_OP_AND    16'b0010_00??_????_????
`define ABE_OP_EOR    16'b0010_01??_????_????
`define ABE_OP_OR     16'b0010_10??_????_????
`define ABE_OP_CPI    16'b0011_????_????_????
`define ABE_OP_SBCK   16'b0100_????_????_????
`define ABE_OP_SUBK   16'b0101_????_????_????
`define ABE_OP_ORK    16'b0110_????_????_????
`define ABE_OP_ANDK   16'b0111_????_????_????
`define ABE_OP_ADDW   16'b1001_0110_????_????
`define ABE_OP_SUBW   16'b1001_0111_????_????
`define ABE_OP_PJMP   16'b1001_0100_0000_1001
`define ABE_OP_PCALL  16'b1001_0101_0000_1001
`define ABE_OP_SKIOC  16'b1001_1001_????_????
`define ABE_OP_SKIOS  16'b1001_1011_????_????
`define ABE_OP_SKRC   16'b1111_110?_????_0???
`define ABE_OP_SKRS   16'b1111_111?_????_0???
`define ABE_OP_BRS    16'b1111_00??_????_????
`define ABE_OP_BRC    16'b1111_01??_????_????
`define ABE_OP_2W_LD  16'b1001_00??_????_0000
`define ABE_OP_2W_JC  16'b1001_010?_????_11??

// ============================================================
// Register numbers
`define ABE_REG_ZLO 5'h1e
`define ABE_REG_ZHI 5'h1f

`endif

//--- rtl/abe_regfile.v
`timescale 1ns/1ps
`default_nettype none
`include "abe_consts.vh"

// ============================================================
// Working register file, two read ports and a pointer port
module abe_regfile (
    input  wire        clk,
    input  wire        we,
    input  wire [4:0]  waddr,
    input  wire [7:0]  wdata,
    input  wire [4:0]  raddr_a,
    input  wire [4:0]  raddr_b,
    output wire [7:0]  rdata_a,
    output wire [7:0]  rdata_b,
    output wire [15:0] z_word
);
    // No reset: software initialises working registers itself
    reg [7:0] regs [0:31];

    always @(posedge clk) begin
        if (we) begin
            regs[waddr] <= wdata;
        end
    end

    assign rdata_a = regs[raddr_a];
    assign rdata_b = regs[raddr_b];
    assign z_word  = {regs[`ABE_REG_ZHI], regs[`ABE_REG_ZLO]};
endmodule // abe_regfile

`default_nettype wire

//--- rtl/abe_alu.v
`timescale 1ns/1ps
`default_nettype none
`include "abe_consts.vh"

// ============================================================
// Byte ALU with flag generation
module abe_alu (
    input  wire [2:0] op,
    input  wire [7:0] a,
    input  wire [7:0] b,
    input  wire       cin,
    input  wire       chain,
    input  wire       zin,
    output reg  [7:0] res,
    output reg        cf,
    output reg        zf,
    output reg        nf,
    output reg        vf,
    output reg        hf
);
    reg [8:0] wide;

    always @* begin
        wide = {1'b0, a} + {1'b0, b} + {8'h00, cin};
        res  = wide[7:0];
        cf   = 1'b0;
        vf   = 1'b0;
        hf   = 1'b0;
        case (op)
            `ABE_ALU_ADD: begin
                cf = wide[8];
                hf = (a[3] & b[3]) | (b[3] & ~res[3]) | (~res[3] & a[3]);
                vf = (a[7] & b[7] & ~res[7]) | (~a[7] & ~b[7] & res[7]);
            end
            `ABE_ALU_SUB: begin
                wide = {1'b0, a} - {1'b0, b} - {8'h00, cin};
                res  = wide[7:0];
                cf   = wide[8];
                hf   = (~a[3] & b[3]) | (b[3] & res[3]) | (res[3] & ~a[3]);
                vf   = (a[7] & ~b[7] & ~res[7]) | (~a[7] & b[7] & res[7]);
            end
            `ABE_ALU_AND: res = a & b;
            `ABE_ALU_OR:  res = a | b;
            `ABE_ALU_EOR: res = a ^ b;
            default:      res = a;
        endcase
        nf = res[7];
        // Borrow chains keep zero only if every byte so far was zero
        zf = (res == 8'h00) & (~chain | zin);
    end
endmodule // abe_alu

`default_nettype wire

//--- sim/abe_core_sva.sv
`timescale 1ns/1ps
`default_nettype none
`include "abe_consts.vh"

// ============================================================
// Port checks of the execute block
module abe_core_sva (
    input wire logic        REF_CLK,
    input wire logic        RESET,
    input wire logic        HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0]  HTRANS,
    input wire logic        HWRITE,
    input wire logic        HREADY,
    input wire logic [31:0] HRDATA,
    input wire logic        HREADYOUT,
    input wire logic        HRESP,
    input wire logic [15:0] PM_ADDR,
    input wire logic [15:0] PM_DATA,
    input wire logic [7:0]  FLAGS_OUT
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (RESET);
    wire rd  = HSEL && HTRANS[1] && HREADY && !HWRITE;
    wire brn = PM_DATA ==? `ABE_OP_BRS || PM_DATA ==? `ABE_OP_BRC;
    wire skp = PM_DATA ==? `ABE_OP_COMPARE_SKIP_EQUAL || PM_DATA ==? `ABE_OP_SKRC
            || PM_DATA ==? `ABE_OP_SKRS || PM_DATA ==? `ABE_OP_SKIOC
            || PM_DATA ==? `ABE_OP_SKIOS;
    AST_READY: assert property (HREADYOUT) else $error("wait state seen");
    AST_OKAY: assert property (!HRESP) else $error("error response");
    AST_UNMAPPED: assert property (rd && HADDR[7:0] > 8'h08 |=>
        HRDATA == 32'h0000_0000) else $error("unmapped read not zero");
    AST_STATUS: assert property (rd && HADDR[7:0] == 8'h04 |=>
        HRDATA[7:0] == $past(FLAGS_OUT)) else $error("status mismatch");
    AST_RST: assert property (disable iff (1'b0) RESET |=>
        PM_ADDR == 16'h0000 && FLAGS_OUT == 8'h00) else $error("reset");
    AST_BR_FLAGS: assert property (brn |=> $stable(FLAGS_OUT))
        else $error("branch changed flags");
    AST_SKIP_FLAGS: assert property (skp |=> $stable(FLAGS_OUT))
        else $error("skip changed flags");
    AST_PJMP: assert property (PM_DATA ==? `ABE_OP_PJMP |=>
        $stable(FLAGS_OUT) [*2]) else $error("jump changed flags");
    AST_PCALL: assert property (PM_DATA ==? `ABE_OP_PCALL |=>
        $stable(FLAGS_OUT) [*3]) else $error("call changed flags");
    cover property (rd && HADDR[7:0] == 8'h04);
    cover property (brn ##1 !brn);
    cover property (skp);
endmodule // abe_core_sva
`default_nettype wire

//--- sim/abe_pmem.sv
`timescale 1ns/1ps
`default_nettype none

// ============================================================
// Program memory, combinational read
module abe_pmem (
    input wire logic [15:0] pm_addr,
    output logic     [15:0] pm_data
);
    logic [15:0] mem [0:15];
    // Outside the loaded words the fetch sees a changing pattern
    assign pm_data = pm_addr < 16'h0010 ? mem[pm_addr[3:0]] : ~pm_addr;
endmodule // abe_pmem
`default_nettype wire

//--- sim/abe_tb.sv
`timescale 1ns/1ps
`default_nettype none

module testbench;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic [31:0] haddr = 32'h0000_0000;
    logic [31:0] hwdata = 32'h0000_0000;
    logic [1:0]  htrans = 2'h0;
    logic        hwrite = 1'b0;
    logic [31:0] hrdata;
    logic        hready, hresp;
    logic [15:0] pm_addr, pm_data;
    logic [7:0]  flags;
    int          miscompares = 0;
    int          checks_done = 0;

    abe_core u_dut (.REF_CLK(clk), .RESET(rst), .HSEL(1'b1), .HADDR(haddr),
        .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(3'h2), .HWDATA(hwdata),
        .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hready), .HRESP(hresp),
        .PM_ADDR(pm_addr), .PM_DATA(pm_data), .IO_BITS({32{8'h5A}}),
        .FLAGS_OUT(flags));
    abe_pmem u_pm (.pm_addr(pm_addr), .pm_data(pm_data));

    initial begin
        forever #5 clk = ~clk;
    end

    task conclude;
        $display("Checks %0d, mismatches %0d", checks_done, miscompares);
        if (miscompares == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            miscompares++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // ========================================================
    // Bus master; entered just after a rising edge
    task ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
             output logic [31:0] rd);
        htrans <= 2'h2;
        haddr <= {24'h00_0000, a};
        hwrite <= wr;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        htrans <= 2'h0;
        hwdata <= wd;
        @(posedge clk);
        while (hready !== 1'b1) @(posedge clk);
        rd = hrdata;
    endtask

    task reset_load(input logic [15:0] w [8]);
        rst <= 1'b1;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        for (int i = 0; i < 16; i++) u_pm.mem[i] = i < 8 ? w[i] : 16'h0000;
    endtask

    task setr(input int n, input logic [7:0] v);
        u_dut.u_regs.regs[n] = v;
    endtask

    // Start, wait for the halt loop, count cycles, stop
    task run(input logic [15:0] halt, input int cyc);
        logic [31:0] d;
        int          n;
        ahb(1'b1, 8'h00, 32'h0000_0001, d);
        n = 0;
        do begin
            @(posedge clk);
            #1 n++;
        end while (pm_addr !== halt && n < 40);
        chk(32'(n), 32'(cyc));
        @(posedge clk);
        ahb(1'b1, 8'h00, 32'h0000_0000, d);
    endtask

    task t_bus;
        logic [31:0] d;
        ahb(1'b0, 8'h04, 32'h0, d); chk(d, 32'h0000_0F00);
        ahb(1'b0, 8'h08, 32'h0, d); chk(d, 32'h0000_0000);
        ahb(1'b1, 8'h0C, 32'hFFFF_FFFF, d);
        ahb(1'b0, 8'h0C, 32'h0, d); chk(d, 32'h0000_0000);
        $display("bus test done");
    endtask

    task t_prog_a;
        logic [31:0] d;
        reset_load('{16'h0F01, 16'hF00D, 16'h7000, 16'h1302,
                     16'h9000, 16'h0000, 16'h9601, 16'h9409});
        setr(16, 8'h0F); setr(17, 8'h01); setr(18, 8'h10);
        setr(24, 8'hFF); setr(25, 8'h00); setr(30, 8'h07); setr(31, 8'h00);
        run(16'h0007, 9);
        chk({24'h0, u_dut.u_regs.regs[16]}, 32'h0000_0010);
        chk({16'h0, u_dut.u_regs.regs[25], u_dut.u_regs.regs[24]},
            32'h0000_0100);
        ahb(1'b0, 8'h04, 32'h0, d); chk(d, 32'h0000_0F20);
        $display("add, branch, skip, word add test done");
    endtask

    task t_prog_b;
        logic [31:0] d;
        reset_load('{16'h1B01, 16'h300F, 16'hFF47, 16'h7000,
                     16'h7F50, 16'hF401, 16'h9409, 16'h0000});
        setr(16, 8'h10); setr(17, 8'h01); setr(20, 8'h80);
        setr(21, 8'hBC); setr(30, 8'h06); setr(31, 8'h00);
        run(16'h0006, 7);
        chk({24'h0, u_dut.u_regs.regs[16]}, 32'h0000_000F);
        chk({24'h0, u_dut.u_regs.regs[21]}, 32'h0000_00B0);
        ahb(1'b0, 8'h04, 32'h0, d); chk(d, 32'h0000_0F14);
        $display("subtract, compare, mask test done");
    endtask

    task t_prog_c;
        logic [31:0] d;
        reset_load('{16'h9B01, 16'h0F01, 16'h9711, 16'h2722,
                     16'h9509, 16'h9409, 16'h0000, 16'h0000});
        setr(16, 8'h33); setr(17, 8'h01); setr(18, 8'h5A);
        setr(26, 8'h00); setr(27, 8'h01); setr(30, 8'h05); setr(31, 8'h00);
        run(16'h0005, 7);
        chk({24'h0, u_dut.u_regs.regs[16]}, 32'h0000_0033);
        chk({24'h0, u_dut.u_regs.regs[18]}, 32'h0000_0000);
        chk({16'h0, u_dut.u_regs.regs[27], u_dut.u_regs.regs[26]},
            32'h0000_00FF);
        chk({16'h0, u_dut.ret_stack[15]}, 32'h0000_0005);
        ahb(1'b0, 8'h04, 32'h0, d); chk(d, 32'h0000_0E02);
        $display("io skip, word subtract, call test done");
    endtask

    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        t_bus();
        t_prog_a();
        t_prog_b();
        t_prog_c();
        conclude();
    end

    initial begin
        #20000;
        miscompares++;
        $display("Error at %0t: watchdog got %h expected %h", $time, 0, 1);
        conclude();
    end
endmodule // testbench

bind abe_core abe_core_sva u_sva (.REF_CLK(REF_CLK), .RESET(RESET),
    .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE),
    .HREADY(HREADY), .HRDATA(HRDATA), .HREADYOUT(HREADYOUT), .HRESP(HRESP),
    .PM_ADDR(PM_ADDR), .PM_DATA(PM_DATA), .FLAGS_OUT(FLAGS_OUT));
`default_nettype wire
